// File: adio_defines.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a 10 MHz pclk and an APB slave with 32-bit data.
`ifndef ADIO_DEFINES_SVH
`define ADIO_DEFINES_SVH

`define ADIO_OFF_SYSTEM_CONTROL_REG      12'h000
`define ADIO_OFF_SYSTEM_STATUS_REG     12'h004
`define ADIO_OFF_AMUX        12'h008
`define ADIO_OFF_HALL        12'h00C
`define ADIO_OFF_RSTAT       12'h010
`define ADIO_OFF_MODE        12'h014

`define ADIO_AMUX_RESET      8'h00
`define ADIO_SLEW_RESET      2'h1

// analog_mux_control fields
`define ADIO_SS_LSB          0
`define ADIO_CSSEL_LSB       4
`define ADIO_CURRENT_SOURCE_ON_BIT        6
`define ADIO_CSA_BIT         7

// Source select codes
`define ADIO_SS_HS_LAST      4'h6
`define ADIO_SS_TEMP         4'h8
`define ADIO_SS_AIN          4'hA
`define ADIO_SS_CAL          4'hB

// Wake filter time in ns and the derived cycle count (least time, ceil)
`define ADIO_CLK_NS          100
`define ADIO_WAKE_FILT_NS    30000
`define ADIO_WAKE_FILT_CYC   ((`ADIO_WAKE_FILT_NS + `ADIO_CLK_NS - 1) / `ADIO_CLK_NS)
// Current-limit shutdown delay in ns and cycles (least time, ceil)
`define ADIO_CL_DELAY_NS     100000
`define ADIO_CL_DELAY_CYC    ((`ADIO_CL_DELAY_NS + `ADIO_CLK_NS - 1) / `ADIO_CLK_NS)

`endif

// File: adio_pkg.sv
// Types shared by the analog die I/O control block.
// Assumes adio_defines.svh holds the numbers.
package adio_pkg;
  typedef enum logic [1:0] {
    ADIO_RUN   = 2'b00,
    ADIO_STOP  = 2'b01,
    ADIO_SLEEP = 2'b10
  } adio_pmode_t;

  typedef enum logic [1:0] {
    ADIO_WK_IDLE = 2'b00,
    ADIO_WK_LOW  = 2'b01,
    ADIO_WK_ARM  = 2'b10
  } adio_wk_state_t;
endpackage

// File: adio_sync_if.sv
// Carrier for one synchronised pin and its change pulse.
// Assumes a single pclk domain.
`timescale 1ns/1ps
`default_nettype none
interface adio_sync_if;
  logic level;
  logic change;
  modport src (output level, output change);
  modport dst (input level, input change);
endinterface
`default_nettype wire

// File: adio_sync.sv
// Three-stage pin synchroniser with change detect.
// Assumes an asynchronous pin input and an active low reset.
`timescale 1ns/1ps
`default_nettype none
module adio_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // System
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Pin and result
  input  wire logic  pin,
  adio_sync_if.src   out
);
  logic [2:0] stage;
  logic       held;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= {3{RESET_VAL}};
      held  <= RESET_VAL;
    end else begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2]) begin
        held <= stage[2];
      end
    end
  end

  // Stages two and three agree on a new value
  assign out.change = (stage[1] == stage[2]) && (stage[2] != held);
  assign out.level  = held;
endmodule // adio_sync
`default_nettype wire

// File: adio_top.sv
// Analog die I/O control: bus transceiver, analog mux, hall and wake pins.
// Assumes an APB master on pclk and asynchronous analog-side inputs.
`timescale 1ns/1ps
`default_nettype none
`include "adio_defines.svh"

// Function
// - Set pin wake flag on wake pin change wake-up; write one clears.
// - Two-bit slew select, reset value picks 20 kBit/s setting.
// - Bus transmitter enabled only while power stage on is set.
// - Current limit sets flag; transceiver disabled after fixed delay.
// - Transmit pin low drives bus dominant, high releases recessive.
// - Transmit pin pulled high internally, keeping bus recessive.
// - Receive pin high for recessive bus, low for dominant.
// - Stop/sleep disable transmitter and pull-up; receiver stays active.
// - Stop, irq enabled: long dominant then rise sets bus irq flag.
// - Sleep: long dominant then rise gives wake reset and flag.
// - Four-bit source select routes one of eleven sources out.
// - Reset clears every analog mux control field.
// - Current source needs power stage on, pin selected, source on.
// - Level select picks 40, 120, 320 or 800 uA.
// - Current source halted in stop and sleep modes.
// - Sense gain bit one low amplification, zero high.
// - Hall mode bit zero general input, one hall sensor input.
// - Hall enable powers pin and senses; flag low on high current.
// - Hall overcurrent sets flag and limits pin current.
// - Hall overcurrent flag cleared by writing one or reset.
// - Run mode: hall level change sets hall irq flag.
// - Bus wake flag cleared by writing one.
module adio_top
  import adio_pkg::*;
#(
  parameter int WAKE_FILT_CYC = `ADIO_WAKE_FILT_CYC,
  parameter int CL_DELAY_CYC  = `ADIO_CL_DELAY_CYC
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Transceiver pins
  input  wire logic        txd_pin,
  input  wire logic        txd_driven,
  output logic             rxd_pin,
  input  wire logic        bus_line,
  input  wire logic        bus_cur_limit,
  output logic             bus_drive_low,
  output logic             bus_pullup_on,
  output logic [1:0]       slew_select,
  // Wake pin and events
  input  wire logic        wake_input_pin,
  output logic             bus_irq,
  output logic             wake_reset_req,
  // Analog multiplexer
  output logic [10:0]      mux_source_sel,
  output logic             mux_idle,
  output logic             cur_src_on,
  output logic [1:0]       current_level_select,
  output logic             cur_src_to_cal,
  output logic             sense_gain_select,
  // Hall pin
  input  wire logic        hall_pin,
  input  wire logic        hall_sense_low,
  input  wire logic        hall_overcur,
  output logic             hall_supply_on,
  output logic             hall_cur_limit,
  output logic             hall_pullup_on,
  output logic             hall_irq_flag
);
  import adio_pkg::*;

  // Elaboration check: each counter needs at least one cycle
  if (WAKE_FILT_CYC < 1 || CL_DELAY_CYC < 1) begin : g_bad_count
    $error("adio_top: counts must be at least one");
  end

  // Synchronised pins
  adio_sync_if rx_s ();
  adio_sync_if wk_s ();
  adio_sync_if hp_s ();
  adio_sync_if hs_s ();
  adio_sync_if cl_s ();
  adio_sync_if ho_s ();

  adio_sync #(.RESET_VAL(1'b1)) u_rx (.pclk(pclk), .presetn(presetn),
    .pin(bus_line), .out(rx_s));
  adio_sync #(.RESET_VAL(1'b0)) u_wk (.pclk(pclk), .presetn(presetn),
    .pin(wake_input_pin), .out(wk_s));
  adio_sync #(.RESET_VAL(1'b1)) u_hp (.pclk(pclk), .presetn(presetn),
    .pin(hall_pin), .out(hp_s));
  adio_sync #(.RESET_VAL(1'b0)) u_hs (.pclk(pclk), .presetn(presetn),
    .pin(hall_sense_low), .out(hs_s));
  adio_sync #(.RESET_VAL(1'b0)) u_cl (.pclk(pclk), .presetn(presetn),
    .pin(bus_cur_limit), .out(cl_s));
  adio_sync #(.RESET_VAL(1'b0)) u_ho (.pclk(pclk), .presetn(presetn),
    .pin(hall_overcur), .out(ho_s));

  // Register map (byte offsets, low byte used)
  // 0x00 control: b0 power stage on, b2:1 slew, b3 bus irq enable
  // 0x04 status: b0 current limit W1C, b1 bus irq W1C, b2 shut off
  // 0x08 analog mux control: b3:0 source, b5:4 level, b6 on, b7 gain
  // 0x0C hall: b0 mode, b1 sense, b2 pull-up off, b4 ovc W1C, b5 irq W1C
  //      b6 hall level (RO), b7 wake pin level (RO)
  // 0x10 wake status: b0 bus wake W1C, b1 pin wake W1C
  // 0x14 power mode: 0 run, 1 stop, 2 sleep; 3 refused
  // Registers
  logic        power_stage_on;
  logic [1:0]  slew_reg;
  logic [1:0]  pmode_reg;
  logic        bus_irq_enable;
  logic        bus_current_limit_flag;
  logic        bus_off;
  logic [7:0]  analog_mux_control;
  logic        hall_mode_select;
  logic        hall_sense_enable;
  logic        hall_pullup_dis;
  logic        hall_overcurrent_flag;
  logic        bus_irq_flag;
  logic        bus_wake_flag;
  logic        pin_wake_flag;
  logic        wake_ref;
  logic [31:0] cl_cnt;
  logic [31:0] wk_cnt;
  adio_wk_state_t wk_state;
  adio_wk_state_t next_wk_state;

  // APB decode
  wire         wr_en   = psel && penable && pwrite;
  wire         byte0   = pstrb[0];
  wire         hit_ctl = paddr == `ADIO_OFF_SYSTEM_CONTROL_REG;
  wire         hit_st  = paddr == `ADIO_OFF_SYSTEM_STATUS_REG;
  wire         hit_mux = paddr == `ADIO_OFF_AMUX;
  wire         hit_hal = paddr == `ADIO_OFF_HALL;
  wire         hit_rs  = paddr == `ADIO_OFF_RSTAT;
  wire         hit_md  = paddr == `ADIO_OFF_MODE;
  wire         mapped  = hit_ctl | hit_st | hit_mux | hit_hal | hit_rs
                         | hit_md;
  wire         w_ctl   = wr_en && hit_ctl && byte0;
  wire         w_mux   = wr_en && hit_mux && byte0;
  wire         w_hal   = wr_en && hit_hal && byte0;
  wire         w_rs    = wr_en && hit_rs && byte0;
  wire         w_md    = wr_en && hit_md && byte0;
  wire         w_st    = wr_en && hit_st && byte0;
  // Write-one-clear strobes
  wire         clr_cl  = w_st && pwdata[0];
  wire         clr_bi  = w_st && pwdata[1];
  wire         clr_ho  = w_hal && pwdata[4];
  wire         clr_hi  = w_hal && pwdata[5];
  wire         clr_bw  = w_rs && pwdata[0];
  wire         clr_pw  = w_rs && pwdata[1];

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Power modes
  adio_pmode_t pmode;
  assign pmode = adio_pmode_t'(pmode_reg);
  wire         in_run   = pmode == ADIO_RUN;
  wire         low_pwr  = (pmode == ADIO_STOP) || (pmode == ADIO_SLEEP);

  // Transceiver
  wire         txd_eff  = txd_driven ? txd_pin : 1'b1;
  wire         tx_en    = power_stage_on && !low_pwr && !bus_off;
  assign bus_drive_low = tx_en && !txd_eff;
  assign bus_pullup_on = !low_pwr;
  assign slew_select   = slew_reg;

  // Source code to one-hot select, nothing for unused codes
  function automatic logic [10:0] src_onehot(input logic [3:0] code);
    logic [10:0] v;
    v = 11'h000;
    if (code <= 4'h6) begin
      v[code] = 1'b1;
    end else if (code >= 4'h8 && code <= 4'hB) begin
      v[code - 4'h1] = 1'b1;
    end
    return v;
  endfunction

  // Analog mux
  wire [3:0]   ss      = analog_mux_control[`ADIO_SS_LSB +: 4];
  wire         ss_used = (ss <= `ADIO_SS_HS_LAST)
                         || (ss >= `ADIO_SS_TEMP && ss <= `ADIO_SS_CAL);
  assign mux_source_sel = ss_used ? src_onehot(ss) : 11'h000;
  assign mux_idle       = !ss_used;
  wire         cs_pin  = (ss == `ADIO_SS_AIN) || (ss == `ADIO_SS_CAL);
  assign cur_src_on = power_stage_on && cs_pin && !low_pwr
                      && analog_mux_control[`ADIO_CURRENT_SOURCE_ON_BIT];
  assign current_level_select =
    analog_mux_control[`ADIO_CSSEL_LSB +: 2];
  assign cur_src_to_cal    = ss == `ADIO_SS_CAL;
  assign sense_gain_select = analog_mux_control[`ADIO_CSA_BIT];

  // Hall pin
  assign hall_supply_on = hall_mode_select && hall_sense_enable;
  assign hall_cur_limit = hall_supply_on && ho_s.level;
  assign hall_pullup_on = !hall_mode_select && !hall_pullup_dis;
  // In hall mode the level flag reads high while sensing is off; in general input mode it follows the pin
  wire         hall_level_flag = hall_mode_select
                 ? !(hall_supply_on && hs_s.level)
                 : hp_s.level;
  wire         hall_chg = hall_mode_select ? hs_s.change && hall_supply_on
                                           : hp_s.change;
  assign rxd_pin = rx_s.level;

  // Bus wake filter: dominant long enough, then rising edge
  wire         wk_fire = wk_state == ADIO_WK_ARM && rx_s.level;
  always_comb begin
    next_wk_state = wk_state;
    case (wk_state)
      ADIO_WK_IDLE: begin
        if (low_pwr && !rx_s.level) next_wk_state = ADIO_WK_LOW;
      end
      ADIO_WK_LOW: begin
        if (!low_pwr || rx_s.level) next_wk_state = ADIO_WK_IDLE;
        else if (wk_cnt >= 32'(WAKE_FILT_CYC)) next_wk_state = ADIO_WK_ARM;
      end
      ADIO_WK_ARM: begin
        if (!low_pwr || rx_s.level) next_wk_state = ADIO_WK_IDLE;
      end
      default: next_wk_state = ADIO_WK_IDLE;
    endcase
  end

  wire         stop_wk  = wk_fire && pmode == ADIO_STOP && bus_irq_enable;
  wire         sleep_wk = wk_fire && pmode == ADIO_SLEEP;
  wire         pin_wk   = low_pwr && wk_s.level != wake_ref;
  assign bus_irq        = bus_irq_flag && bus_irq_enable;
  assign wake_reset_req = sleep_wk || (pmode == ADIO_SLEEP && pin_wk);
  // Only a wake that is taken returns the block to run mode
  wire         wake_any = stop_wk || sleep_wk || pin_wk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_state <= ADIO_WK_IDLE;
      wk_cnt   <= 32'h00000000;
    end else begin
      wk_state <= next_wk_state;
      wk_cnt   <= (next_wk_state == ADIO_WK_LOW) ? wk_cnt + 32'h1
                                                 : 32'h00000000;
    end
  end

  // Current limit shutdown timer
  // Count restarts whenever the limit or the enable drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_cnt  <= 32'h00000000;
      bus_off <= 1'b0;
    end else begin
      cl_cnt  <= (cl_s.level && tx_en) ? cl_cnt + 32'h1 : 32'h00000000;
      if (cl_cnt >= 32'(CL_DELAY_CYC)) bus_off <= 1'b1;
      else if (!power_stage_on) bus_off <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_stage_on     <= 1'b0;
      slew_reg           <= `ADIO_SLEW_RESET;
      bus_irq_enable     <= 1'b0;
      pmode_reg          <= 2'h0;
      analog_mux_control <= `ADIO_AMUX_RESET;
      hall_mode_select   <= 1'b0;
      hall_sense_enable  <= 1'b0;
      hall_pullup_dis    <= 1'b0;
      wake_ref           <= 1'b0;
    end else begin
      if (w_ctl) begin
        power_stage_on <= pwdata[0];
        slew_reg       <= pwdata[2:1];
        bus_irq_enable <= pwdata[3];
      end
      if (w_md && pwdata[1:0] != 2'h3) pmode_reg <= pwdata[1:0];
      else if (wake_any) pmode_reg <= 2'h0;
      if (w_mux) analog_mux_control <= pwdata[7:0];
      if (w_hal) begin
        hall_mode_select  <= pwdata[0];
        hall_sense_enable <= pwdata[1];
        hall_pullup_dis   <= pwdata[2];
      end
      // Pin level latched in run; a change in stop or sleep wakes
      if (!low_pwr) wake_ref <= wk_s.level;
    end
  end

  // Sticky flags: set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_current_limit_flag <= 1'b0;
      hall_overcurrent_flag  <= 1'b0;
      hall_irq_flag          <= 1'b0;
      bus_irq_flag           <= 1'b0;
      bus_wake_flag          <= 1'b0;
      pin_wake_flag          <= 1'b0;
    end else begin
      bus_current_limit_flag <= (cl_s.level && tx_en)
        || (bus_current_limit_flag && !clr_cl);
      hall_overcurrent_flag <= (ho_s.level && hall_supply_on)
        || (hall_overcurrent_flag && !clr_ho);
      hall_irq_flag <= (in_run && hall_chg)
        || (hall_irq_flag && !clr_hi);
      bus_irq_flag <= stop_wk
        || (bus_irq_flag && !clr_bi);
      bus_wake_flag <= sleep_wk
        || (bus_wake_flag && !clr_bw);
      pin_wake_flag <= pin_wk
        || (pin_wake_flag && !clr_pw);
    end
  end

  // Read mux
  always_comb begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      if (hit_ctl) prdata[3:0] = {bus_irq_enable, slew_reg, power_stage_on};
      if (hit_st)  prdata[2:0] = {bus_off, bus_irq_flag,
                                  bus_current_limit_flag};
      if (hit_mux) prdata[7:0] = analog_mux_control;
      if (hit_hal) prdata[7:0] = {wk_s.level, hall_level_flag,
                                  hall_irq_flag, hall_overcurrent_flag,
                                  1'b0, hall_pullup_dis, hall_sense_enable,
                                  hall_mode_select};
      if (hit_rs)  prdata[1:0] = {pin_wake_flag, bus_wake_flag};
      if (hit_md)  prdata[1:0] = pmode_reg;
    end
  end
endmodule // adio_top
`default_nettype wire

// File: adio_sva.sv
// Port checker for the analog die I/O control top.
// Assumes one pclk domain with active low presetn.
`timescale 1ns/1ps
`default_nettype none
module adio_sva #(
  parameter int WAKE_FILT_CYC = 4,
  parameter int CL_DELAY_CYC  = 8
) (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Transceiver and wake
  input wire logic        txd_pin,
  input wire logic        txd_driven,
  input wire logic        rxd_pin,
  input wire logic        bus_line,
  input wire logic        bus_cur_limit,
  input wire logic        bus_drive_low,
  input wire logic        bus_pullup_on,
  input wire logic        bus_irq,
  input wire logic        wake_reset_req,
  // Analog mux
  input wire logic [10:0] mux_source_sel,
  input wire logic        mux_idle,
  input wire logic        cur_src_on
);
  // Cycles the current limit has stood
  int cl_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cl_cnt <= 0;
    else cl_cnt <= bus_cur_limit ? cl_cnt + 1 : 0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TX_DOM: assert property (
    bus_drive_low |-> txd_driven && !txd_pin) else $error("bad drive low");
  AST_CL_SHUT: assert property (
    cl_cnt > CL_DELAY_CYC + 6 |-> !bus_drive_low)
    else $error("no limit shutdown");
  AST_RXD: assert property (
    $stable(bus_line) [*6] |-> rxd_pin == bus_line)
    else $error("receive pin wrong");
  AST_MUX_1H: assert property (
    $onehot0(mux_source_sel) && mux_idle == (mux_source_sel == 11'h000))
    else $error("mux select not one-hot");
  AST_CS_PIN: assert property (
    cur_src_on |-> mux_source_sel[9] || mux_source_sel[10])
    else $error("source on, pin unselected");
  AST_LP_OFF: assert property (
    !bus_pullup_on |-> !bus_drive_low && !cur_src_on)
    else $error("active in low power");
  AST_SLVERR: assert property (
    psel && penable && paddr > 12'h014 |-> pready && pslverr)
    else $error("unmapped not refused");
  AST_WAKE_PULSE: assert property (
    wake_reset_req |=> !wake_reset_req) else $error("wake reset too long");
  AST_IRQ_HOLD: assert property (
    bus_irq && !(psel && penable && pwrite) |=> bus_irq)
    else $error("bus irq dropped");

  cover property (bus_irq);
  cover property (wake_reset_req);
  cover property (cur_src_on && mux_source_sel[9]);
endmodule // adio_sva

bind adio_top adio_sva #(
  .WAKE_FILT_CYC(WAKE_FILT_CYC), .CL_DELAY_CYC(CL_DELAY_CYC)
) i_adio_sva (.*);
`default_nettype wire

// File: adio_bus_model.sv
// Far side of the single-wire bus: pull-up and other nodes.
// Assumes a wired-AND line that idles recessive.
`timescale 1ns/1ps
`default_nettype none
module adio_bus_model (
  // Drivers
  input  wire logic dev_drive_low,
  input  wire logic node_dominant,
  // Line
  output logic      bus_line
);
  // Released line returns to pull-up level
  assign bus_line = !(dev_drive_low || node_dominant);
endmodule // adio_bus_model
`default_nettype wire

// File: analog_die_io_control_tb_top.sv
// Bench for the analog die I/O control top with a bus line model.
// Assumes adio_top, adio_bus_model and the checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module analog_die_io_control_tb_top;
  localparam int WF = 4;
  localparam int CL = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        txd_pin, txd_driven, rxd_pin, bus_line, bus_cur_limit;
  logic        bus_drive_low, bus_pullup_on, wake_input_pin, bus_irq;
  logic        wake_reset_req, mux_idle, cur_src_on, cur_src_to_cal;
  logic        sense_gain_select, hall_pin, hall_sense_low, hall_overcur;
  logic        hall_supply_on, hall_cur_limit, hall_pullup_on;
  logic        hall_irq_flag, node_dom, err;
  logic [1:0]  slew_select, current_level_select;
  logic [10:0] mux_source_sel;
  logic [7:0]  v;
  int          mismatches, total_checks;
  int          amux_q[$];

  adio_top #(.WAKE_FILT_CYC(WF), .CL_DELAY_CYC(CL)) i_adio_top (.*);
  adio_bus_model i_adio_bus_model (
    .dev_drive_low(bus_drive_low),
    .node_dominant(node_dom),
    .bus_line     (bus_line)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, exp);
    apb(1'b0, a, 32'h0, rd, err);
    check(rd & m, exp);
  endtask

  // Long dominant from another node, then wait for the wake event
  task automatic wake(input logic want_rst);
    int n;
    @(posedge pclk);
    node_dom <= 1'b1;
    repeat (WF + 6 + $urandom_range(4)) @(posedge pclk);
    node_dom <= 1'b0;
    n = 0;
    while ((want_rst ? wake_reset_req : bus_irq) !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      end_of_test();
    end
  endtask

  function automatic logic [10:0] exp_sel(input int c);
    if (c <= 6) return 11'h001 << c;
    if (c >= 8 && c <= 11) return 11'h001 << (c - 1);
    return 11'h000;
  endfunction

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, txd_pin, txd_driven} = 5'b00010;
    {bus_cur_limit, node_dom, wake_input_pin, hall_pin} = 4'b0011;
    {hall_sense_low, hall_overcur} = 2'b00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    mismatches = 0;
    total_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(46008));
    rdc(12'h000, 32'hF, 32'h2);
    check(slew_select, 2'h1);
    check(hall_pullup_on, 1'b1);
    rdc(12'h008, 32'hFF, 32'h0);
    wr(12'h000, 32'h3);
    for (int c = 0; c < 16; c++) begin
      v = {4'($urandom()), 4'(c)};
      wr(12'h008, {24'h0, v});
      amux_q.push_back(v);
      @(negedge pclk);
      check(mux_source_sel, exp_sel(c));
      check(mux_idle, exp_sel(c) == 11'h000);
      check(current_level_select, v[5:4]);
      check(sense_gain_select, v[7]);
      check(cur_src_on, v[6] && c >= 10 && c <= 11);
      check(cur_src_to_cal, c == 11);
      rdc(12'h008, 32'hFF, amux_q.pop_front());
    end
    wr(12'h008, 32'h4A);
    wr(12'h000, 32'h2);
    @(negedge pclk);
    check(cur_src_on, 1'b0);
    wr(12'h000, 32'h3);
    txd_driven <= 1'b1;
    txd_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    check(bus_drive_low, 1'b1);
    check(rxd_pin, 1'b0);
    txd_driven <= 1'b0;
    repeat (6) @(posedge pclk);
    check(bus_drive_low, 1'b0);
    check(rxd_pin, 1'b1);
    txd_driven <= 1'b1;
    bus_cur_limit <= 1'b1;
    repeat (CL + 8) @(posedge pclk);
    check(bus_drive_low, 1'b0);
    rdc(12'h004, 32'h5, 32'h5);
    bus_cur_limit <= 1'b0;
    wr(12'h000, 32'h2);
    @(negedge pclk);
    check(bus_drive_low, 1'b0);
    txd_pin <= 1'b1;
    wr(12'h004, 32'h1);
    rdc(12'h004, 32'h5, 32'h0);
    wr(12'h000, 32'hA);
    wr(12'h014, 32'h1);
    @(negedge pclk);
    check(bus_pullup_on, 1'b0);
    wake(1'b0);
    rdc(12'h004, 32'h2, 32'h2);
    wr(12'h004, 32'h2);
    rdc(12'h004, 32'h2, 32'h0);
    wr(12'h014, 32'h2);
    wake(1'b1);
    rdc(12'h010, 32'h1, 32'h1);
    rdc(12'h014, 32'h3, 32'h0);
    wr(12'h010, 32'h1);
    rdc(12'h010, 32'h1, 32'h0);
    wr(12'h014, 32'h1);
    wake_input_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    rdc(12'h010, 32'h2, 32'h2);
    wr(12'h010, 32'h2);
    rdc(12'h010, 32'h2, 32'h0);
    apb(1'b0, 12'h018, 32'h0, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0);
    wr(12'h00C, 32'h3);
    repeat (400) @(posedge pclk); // sensor settles before reading
    check(hall_supply_on, 1'b1);
    check(hall_pullup_on, 1'b0);
    rdc(12'h00C, 32'h40, 32'h40);
    hall_sense_low <= 1'b1;
    repeat (8) @(posedge pclk);
    rdc(12'h00C, 32'h60, 32'h20);
    check(hall_irq_flag, 1'b1);
    wr(12'h00C, 32'h23);
    rdc(12'h00C, 32'h20, 32'h0);
    hall_overcur <= 1'b1;
    repeat (8) @(posedge pclk);
    check(hall_cur_limit, 1'b1);
    hall_overcur <= 1'b0;
    repeat (8) @(posedge pclk);
    check(hall_cur_limit, 1'b0);
    rdc(12'h00C, 32'h10, 32'h10);
    wr(12'h00C, 32'h13);
    rdc(12'h00C, 32'h10, 32'h0);
    end_of_test();
  end
endmodule // analog_die_io_control_tb_top
`default_nettype wire
